// file: verilog/lcst_handler.sv
// Lifecycle transit command handler: parses framed command packets,
// checks them, commits the new lifecycle state and queues the reply.
// Assumes rx bytes and flash answers come from logic on the same clock.
// Summary of operation
// (R01) Failure address: flash error address, else all ones
// (R02) State codes 04,06,07,08,09 in one byte
// (R03) Commands only accepted in allowed lifecycle states
// (R04) Locked loader state: software reset, never accept
// (R05) Transit commits without any authentication exchange
// (R06) After locked or final state, halt forever
// (R07) Host frames 01,00,03,71,src,dst,sum,03
// (R08) Source field is owner or return-acknowledged
// (R09) Target field is locked loader or final
// (R10) Success reply 81,00,0a,71,00,ones,ones,8d,03
// (R11) Failure reply carries f1, status, detail, address
// (R12) Reply code is opcode, plus 80h on error
// (R13) Status codes d0,d5,da,c1,c2,e5,d7 used
// (R14) Parameter error on mismatch; protection error if disabled
// (R15) Discard to start byte; packet/checksum errors
// (R16) Check byte makes summed bytes total zero
`timescale 1ns/1ps
module lcst_handler
    import lcst_pkg::*;
(
    input  wire logic            clk,           // 50 MHz clock
    input  wire logic            rst,           // Async reset, active high
    input  wire logic [7:0]      lc_state_in,   // Stored state at boot
    input  wire logic            lock_enable,   // Locked target allowed
    input  wire logic            rx_valid,      // Command byte offered
    output logic                 rx_ready,      // Command byte taken
    input  wire logic [7:0]      rx_data,       // Command byte
    output logic                 tx_valid,      // Reply byte present
    input  wire logic            tx_ready,      // Link takes reply byte
    output logic      [7:0]      tx_data,       // Reply byte
    output lcst_flash_req_t      flash_req,     // Commit request
    input  wire lcst_flash_rsp_t flash_rsp,     // Commit answer
    output logic      [7:0]      lc_state,      // Current state
    output logic                 sw_reset_req,  // Software reset request
    output logic                 halted         // Permanently idle
);
    typedef struct packed {
        lcst_fsm_t   fsm;
        logic [7:0]  lc;
        logic [15:0] len;
        logic [15:0] cnt;
        logic [7:0]  sum;
        logic [7:0]  op;
        logic [7:0]  src;
        logic [7:0]  dst;
        logic        etx_ok;
        logic [7:0]  sts;
        logic [31:0] detail;
        logic [31:0] addr;
        logic        halt_after;
        logic        swrst;
        logic        freq;
    } lcst_st_t;

    lcst_st_t   s_reg;
    lcst_st_t   s_next;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic       take;
    logic [3:0] ridx;
    logic [7:0] rcode;

    ////////////////////////////////////////////////////////////////////////
    // Reply byte for indices 0..12 and the trailing end byte
    function automatic logic [7:0] raw_byte(input logic [3:0]  i,
                                            input logic [7:0]  code,
                                            input logic [7:0]  sts,
                                            input logic [31:0] det,
                                            input logic [31:0] adr);
        logic [7:0] b;
        b = END_BYTE;
        case (i)
            4'h0: b = REPLY_HEADER_BYTE;
            4'h1: b = REPLY_LEN_HIGH;
            4'h2: b = REPLY_LEN_LOW;
            4'h3: b = code;
            4'h4: b = sts;
            4'h5: b = det[31:24];
            4'h6: b = det[23:16];
            4'h7: b = det[15:8];
            4'h8: b = det[7:0];
            4'h9: b = adr[31:24];
            4'ha: b = adr[23:16];
            4'hb: b = adr[15:8];
            4'hc: b = adr[7:0];
            default: b = END_BYTE;
        endcase
        return b;
    endfunction : raw_byte

    // Two's complement of the sum of length through last payload byte
    function automatic logic [7:0] reply_sum(input logic [7:0]  code,
                                             input logic [7:0]  sts,
                                             input logic [31:0] det,
                                             input logic [31:0] adr);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 1; i <= 12; i++) begin
            acc = acc + raw_byte(4'(i), code, sts, det, adr);
        end
        return 8'(-acc); // [R16]
    endfunction : reply_sum

    // Lifecycle codes that the hardware may hold
    function automatic logic valid_lc(input logic [7:0] c);
        return (c == LC_OWNER) || (c == LC_LOCKED) || (c == LC_RET_REQ) ||
               (c == LC_RET_ACK) || (c == LC_RET_FIN); // [R02]
    endfunction : valid_lc

    ////////////////////////////////////////////////////////////////////////
    // Handshakes and reply stream
    assign rx_ready = (s_reg.fsm == LCST_WAIT) || (s_reg.fsm == LCST_LENH) ||
                      (s_reg.fsm == LCST_LENL) || (s_reg.fsm == LCST_PAYLD) ||
                      (s_reg.fsm == LCST_SUMB) || (s_reg.fsm == LCST_ETXB);
    assign take     = rx_valid && rx_ready;
    // Reply code follows the opcode, error bit added on failure
    assign rcode = (s_reg.sts == ST_OK) ? s_reg.op
                                        : (s_reg.op | ERR_BIT); // [R12]
    // Reply index: wire byte order has the sum at 13 before end byte
    assign ridx  = s_reg.cnt[3:0];
    assign fifo_in_valid = (s_reg.fsm == LCST_SEND);
    always_comb begin
        if (ridx == REPLY_LAST_IDX) begin
            fifo_in_data = END_BYTE;
        end else if (ridx == REPLY_SUM_IDX + 4'h1) begin
            fifo_in_data = reply_sum(rcode, s_reg.sts, s_reg.detail,
                                     s_reg.addr); // [R10] [R11]
        end else begin
            fifo_in_data = raw_byte(ridx, rcode, s_reg.sts, s_reg.detail,
                                    s_reg.addr); // [R10] [R11]
        end
    end

    assign flash_req.req    = s_reg.freq;
    assign flash_req.target = s_reg.dst;
    assign lc_state         = s_reg.lc;
    assign sw_reset_req     = s_reg.swrst;
    assign halted           = (s_reg.fsm == LCST_HALT);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_next      = s_reg;
        s_next.freq = 1'b0;
        case (s_reg.fsm)
            LCST_INIT: begin
                // Stored state caught on the first edge after reset
                s_next.lc  = lc_state_in;
                s_next.fsm = (lc_state_in == LC_LOCKED) ? LCST_SWRST
                                                        : LCST_WAIT; // [R04]
            end
            LCST_SWRST: begin
                s_next.swrst = 1'b1; // [R04]
                s_next.fsm   = LCST_HALT;
            end
            LCST_WAIT: begin
                // Bytes other than the start byte are dropped
                if (take && rx_data == START_BYTE) begin // [R15]
                    s_next.fsm = LCST_LENH;
                    s_next.sum = 8'h00;
                    s_next.op  = 8'h00;
                    s_next.src = 8'h00;
                    s_next.dst = 8'h00;
                end
            end
            LCST_LENH: begin
                if (take) begin
                    s_next.len[15:8] = rx_data;
                    s_next.sum       = s_reg.sum + rx_data; // [R16]
                    s_next.fsm       = LCST_LENL;
                end
            end
            LCST_LENL: begin
                if (take) begin
                    s_next.len[7:0] = rx_data;
                    s_next.sum      = s_reg.sum + rx_data;
                    s_next.cnt      = 16'h0000;
                    s_next.fsm      = ({s_reg.len[15:8], rx_data} == 16'h0000)
                                      ? LCST_SUMB : LCST_PAYLD;
                end
            end
            LCST_PAYLD: begin
                if (take) begin
                    case (s_reg.cnt)
                        16'h0000: s_next.op  = rx_data;
                        16'h0001: s_next.src = rx_data;
                        16'h0002: s_next.dst = rx_data;
                        default:  s_next.op  = s_reg.op;
                    endcase
                    s_next.sum = s_reg.sum + rx_data;
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cnt + 16'h0001 == s_reg.len) begin
                        s_next.fsm = LCST_SUMB;
                    end
                end
            end
            LCST_SUMB: begin
                if (take) begin
                    s_next.sum = s_reg.sum + rx_data; // [R16]
                    s_next.fsm = LCST_ETXB;
                end
            end
            LCST_ETXB: begin
                if (take) begin
                    s_next.etx_ok = (rx_data == END_BYTE);
                    s_next.fsm    = LCST_EVAL;
                end
            end
            LCST_EVAL: begin
                // Checks in descending priority; no authentication needed
                s_next.detail = UNUSED_WORD;
                s_next.addr   = UNUSED_WORD; // [R01]
                s_next.cnt    = 16'h0000;
                s_next.fsm    = LCST_SEND;
                s_next.sts    = ST_OK;
                if (!s_reg.etx_ok) begin
                    s_next.sts = ST_PACKET; // [R15]
                end else if (s_reg.sum != 8'h00) begin
                    s_next.sts = ST_CHECKSUM; // [R15] [R16]
                end else if (s_reg.op != OPC_TRANSIT) begin
                    s_next.sts = ST_UNSUP;
                end else if (s_reg.len != TRANSIT_LEN) begin
                    s_next.sts = ST_PACKET; // [R15]
                end else if (s_reg.lc != LC_OWNER &&
                             s_reg.lc != LC_RET_ACK) begin
                    s_next.sts = ST_ACCEPT; // [R03] [R13]
                end else if (s_reg.src != s_reg.lc) begin
                    s_next.sts = ST_PARAM; // [R14]
                end else if (!((s_reg.lc == LC_OWNER &&
                                s_reg.dst == LC_LOCKED) ||
                               (s_reg.lc == LC_RET_ACK &&
                                s_reg.dst == LC_RET_FIN))) begin
                    s_next.sts = ST_PARAM; // [R14]
                end else if (s_reg.dst == LC_LOCKED && !lock_enable) begin
                    s_next.sts = ST_PROTECT; // [R14]
                end else begin
                    s_next.freq = 1'b1; // [R05]
                    s_next.fsm  = LCST_FLASH;
                end
            end
            LCST_FLASH: begin
                if (flash_rsp.done) begin
                    s_next.fsm = LCST_SEND;
                    if (flash_rsp.err) begin
                        s_next.sts    = ST_FLASH; // [R13]
                        s_next.detail = flash_rsp.status;
                        s_next.addr   = flash_rsp.addr; // [R01]
                    end else if (!valid_lc(flash_rsp.state_rd)) begin
                        s_next.sts        = ST_HW;
                        s_next.halt_after = 1'b1;
                    end else begin
                        s_next.lc         = flash_rsp.state_rd;
                        s_next.halt_after = (flash_rsp.state_rd ==
                                             LC_LOCKED) ||
                                            (flash_rsp.state_rd ==
                                             LC_RET_FIN); // [R06]
                    end
                end
            end
            LCST_SEND: begin
                if (fifo_in_ready) begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (ridx == REPLY_LAST_IDX) begin
                        s_next.fsm = s_reg.halt_after ? LCST_HALT
                                                      : LCST_WAIT; // [R06]
                    end
                end
            end
            LCST_HALT: begin
                s_next.fsm = LCST_HALT; // [R06]
            end
            default: begin
                s_next.fsm = LCST_HALT;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply FIFO toward the link
    lcst_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic push;
    assign push = fifo_in_valid && fifo_in_ready;

    property p_halt_stays;
        @(posedge clk) disable iff (rst)
        halted |=> (halted && !rx_ready) [*4];
    endproperty
    a_halt_stays: assert property (p_halt_stays) // [R06]
        else $error("Halted handler woke up");

    property p_swreset;
        @(posedge clk) disable iff (rst)
        (s_reg.fsm == LCST_INIT && lc_state_in == LC_LOCKED)
            |=> ##1 sw_reset_req && halted;
    endproperty
    a_swreset: assert property (p_swreset) // [R04]
        else $error("Locked boot did not request reset");

    property p_commit_legal;
        @(posedge clk) disable iff (rst)
        flash_req.req |-> (lc_state == LC_OWNER &&
                           flash_req.target == LC_LOCKED && lock_enable) ||
                          (lc_state == LC_RET_ACK &&
                           flash_req.target == LC_RET_FIN);
    endproperty
    a_commit_legal: assert property (p_commit_legal) // [R14]
        else $error("Commit requested for illegal transition");

    property p_accept_state;
        @(posedge clk) disable iff (rst)
        flash_req.req |-> $past(s_reg.fsm) == LCST_EVAL &&
                          lc_state != LC_RET_REQ;
    endproperty
    a_accept_state: assert property (p_accept_state) // [R03]
        else $error("Command executed in a refused state");

    property p_header;
        @(posedge clk) disable iff (rst)
        push && ridx == 4'h0 |=> push && fifo_in_data == REPLY_LEN_HIGH
            ##1 push && fifo_in_data == REPLY_LEN_LOW;
    endproperty
    a_header: assert property (p_header) // [R11]
        else $error("Reply header bytes wrong");

    property p_code;
        @(posedge clk) disable iff (rst)
        push && ridx == 4'h3 |-> fifo_in_data ==
            {(s_reg.sts != ST_OK) || s_reg.op[7], s_reg.op[6:0]};
    endproperty
    a_code: assert property (p_code) // [R12]
        else $error("Reply code does not follow outcome");

    property p_addr;
        @(posedge clk) disable iff (rst)
        push && ridx >= 4'h9 && ridx <= 4'hc && s_reg.sts != ST_FLASH
            |-> fifo_in_data == 8'hff;
    endproperty
    a_addr: assert property (p_addr) // [R01]
        else $error("Failure address not all ones");

    property p_ok_sum;
        @(posedge clk) disable iff (rst)
        push && ridx == 4'hd &&
            s_reg.sts == ST_OK &&
            s_reg.op == OPC_TRANSIT
            |-> fifo_in_data == 8'h8d;
    endproperty
    a_ok_sum: assert property (p_ok_sum) // [R10]
        else $error("Success check byte wrong");

    property p_discard;
        @(posedge clk) disable iff (rst)
        s_reg.fsm == LCST_WAIT && rx_valid && rx_data != START_BYTE
            |=> s_reg.fsm == LCST_WAIT;
    endproperty
    a_discard: assert property (p_discard) // [R15]
        else $error("Non-start byte left wait state");
endmodule : lcst_handler

// file: verilog/lcst_pkg.sv
// Shared constants and carrier types for the lifecycle transit handler.
// Assumes one 50 MHz clock domain; the byte link and the flash sequencer
// sit on the same clock as this block.
package lcst_pkg;
    // Framing bytes
    localparam logic [7:0]  START_BYTE        = 8'h01;
    localparam logic [7:0]  END_BYTE          = 8'h03;
    localparam logic [7:0]  REPLY_HEADER_BYTE = 8'h81;
    localparam logic [7:0]  OPC_TRANSIT       = 8'h71;
    localparam logic [7:0]  ERR_BIT           = 8'h80;
    localparam logic [15:0] TRANSIT_LEN       = 16'h0003;
    localparam logic [7:0]  REPLY_LEN_HIGH    = 8'h00;
    localparam logic [7:0]  REPLY_LEN_LOW     = 8'h0a;
    localparam logic [31:0] UNUSED_WORD       = 32'hffffffff;
    localparam logic [3:0]  REPLY_LAST_IDX    = 4'he;
    localparam logic [3:0]  REPLY_SUM_IDX     = 4'hc;
    // Lifecycle state codes
    localparam logic [7:0]  LC_OWNER    = 8'h04;
    localparam logic [7:0]  LC_LOCKED   = 8'h06;
    localparam logic [7:0]  LC_RET_REQ  = 8'h07;
    localparam logic [7:0]  LC_RET_ACK  = 8'h08;
    localparam logic [7:0]  LC_RET_FIN  = 8'h09;
    // Status codes
    localparam logic [7:0]  ST_OK       = 8'h00;
    localparam logic [7:0]  ST_UNSUP    = 8'hc0;
    localparam logic [7:0]  ST_PACKET   = 8'hc1;
    localparam logic [7:0]  ST_CHECKSUM = 8'hc2;
    localparam logic [7:0]  ST_PARAM    = 8'hd0;
    localparam logic [7:0]  ST_ACCEPT   = 8'hd5;
    localparam logic [7:0]  ST_HW       = 8'hd7;
    localparam logic [7:0]  ST_PROTECT  = 8'hda;
    localparam logic [7:0]  ST_FLASH    = 8'he5;
    // Reply FIFO shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // Handler states
    typedef enum logic [3:0] {
        LCST_INIT  = 4'b0000,
        LCST_SWRST = 4'b0001,
        LCST_WAIT  = 4'b0010,
        LCST_LENH  = 4'b0011,
        LCST_LENL  = 4'b0100,
        LCST_PAYLD = 4'b0101,
        LCST_SUMB  = 4'b0110,
        LCST_ETXB  = 4'b0111,
        LCST_EVAL  = 4'b1000,
        LCST_FLASH = 4'b1001,
        LCST_SEND  = 4'b1010,
        LCST_HALT  = 4'b1011
    } lcst_fsm_t;

    // Answer from the flash sequencer after a commit
    typedef struct packed {
        logic        done;
        logic        err;
        logic [31:0] status;
        logic [31:0] addr;
        logic [7:0]  state_rd;
    } lcst_flash_rsp_t;

    // Commit request to the flash sequencer
    typedef struct packed {
        logic       req;
        logic [7:0] target;
    } lcst_flash_req_t;
endpackage : lcst_pkg

// file: verilog/lcst_fifo.sv
// Reply byte FIFO with a registered output stage.
// Assumes both sides share the clock; out_ready may stall at will.
`timescale 1ns/1ps
module lcst_fifo
    import lcst_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,       // System clock
    input  wire logic             rst,       // Async reset, active high
    input  wire logic             in_valid,  // Write offered
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Word written
    output logic                  out_valid, // Head word present
    input  wire logic             out_ready, // Reader takes head
    output logic      [WIDTH-1:0] out_data   // Head word, registered
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0]  wr;
        logic [AW-1:0]  rd;
        logic [AW:0]    cnt;
        logic           hv;
        logic [WIDTH-1:0] head;
    } lcst_fifo_st_t;

    lcst_fifo_st_t    s_reg;
    lcst_fifo_st_t    s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes
    assign in_ready  = (s_reg.cnt != (AW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    assign pop       = (s_reg.cnt != '0) && (!s_reg.hv || out_ready);
    assign out_valid = s_reg.hv;
    assign out_data  = s_reg.head;

    // Pointer and head update
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (pop) begin
            s_next.rd   = s_reg.rd + 1'b1;
            s_next.head = mem[s_reg.rd];
            s_next.hv   = 1'b1;
        end else if (out_ready) begin
            s_next.hv = 1'b0;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_reg.wr] <= in_data;
        end
    end
endmodule : lcst_fifo

// file: tb/lcst_flash_model.sv
// Flash sequencer stand-in: answers each commit four cycles after the request.
// Assumes the handler clock; err_mode fails every commit answered while it is high.
`timescale 1ns/1ps
module lcst_flash_model
    import lcst_pkg::*;
#(
    parameter logic [31:0] STS = 32'h0000_4010,
    parameter logic [31:0] ADR = 32'h0000_2000
) (
    input  wire logic            clk,      // System clock
    input  wire logic            rst,      // Async reset, active high
    input  wire lcst_flash_req_t req,      // Commit request
    input  wire logic            err_mode, // Fail the commit
    output lcst_flash_rsp_t      rsp       // Commit answer
);
    logic [1:0] cnt_reg;
    ///////////////////////////////////////////////////////////////////////
    // Count down from the request, then pulse done for one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 2'h0;
            rsp     <= '0;
        end else begin
            rsp.done     <= (cnt_reg == 2'h1);
            rsp.err      <= err_mode;
            rsp.status   <= err_mode ? STS : 32'hffffffff;
            rsp.addr     <= ADR;
            rsp.state_rd <= req.target;
            if (req.req)
                cnt_reg <= 2'h3;
            else if (cnt_reg != 2'h0)
                cnt_reg <= cnt_reg - 2'h1;
        end
    end
endmodule : lcst_flash_model

// file: tb/lifecycle_state_transit_cmd_tb.sv
// Bench for the transit handler: frames commands and checks replies.
// Assumes lcst_flash_model answers every commit request.
`timescale 1ns/1ps
module lifecycle_state_transit_cmd_tb;
    import lcst_pkg::*;
    localparam logic [31:0] FSTS = 32'h0000_4010;
    localparam logic [31:0] FADR = 32'h0000_2000;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic [7:0]      st_in = LC_OWNER;
    logic            lock_en = 1'b1;
    logic            rx_valid = 1'b0;
    logic            rx_ready;
    logic [7:0]      rx_data = 8'h00;
    logic            tx_valid;
    logic            tx_ready = 1'b0;
    logic [7:0]      tx_data;
    logic            err_mode = 1'b0;
    lcst_flash_req_t freq;
    lcst_flash_rsp_t frsp;
    logic [7:0]      lc_state;
    logic            swr;
    logic            halted;
    int              mismatches = 0;
    int              n_checks = 0;

    always #10 clk = ~clk;

    lcst_handler DUT (.clk(clk), .rst(rst), .lc_state_in(st_in),
        .lock_enable(lock_en), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .flash_req(freq), .flash_rsp(frsp),
        .lc_state(lc_state), .sw_reset_req(swr), .halted(halted));
    lcst_flash_model #(.STS(FSTS), .ADR(FADR)) FLASH (.clk(clk),
        .rst(rst), .req(freq), .err_mode(err_mode), .rsp(frsp));
    ///////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Wait for a flag at falling edges, giving up after 200 cycles
    task automatic wait_hi(ref logic sig);
        int n;
        n = 0;
        @(negedge clk);
        while (sig !== 1'b1) begin
            n++;
            if (n > 200) begin
                mismatches++;
                tally_and_finish();
            end
            @(negedge clk);
        end
    endtask : wait_hi
    task automatic boot(input logic [7:0] s);
        rst = 1'b1;
        st_in = s;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
    endtask : boot
    // Junk byte first, then a full frame; bad[0] spoils the check byte,
    // bad[1] the end byte
    task automatic send(input logic [7:0] src, dst, input logic [1:0] bad);
        logic [7:0] b [9];
        b = '{8'h55, START_BYTE, 8'h00, 8'h03, OPC_TRANSIT, src, dst,
              8'h00, END_BYTE};
        b[7] = 8'h00 - (8'h03 + OPC_TRANSIT + src + dst) +
               {7'h0, bad[0]};
        if (bad[1])
            b[8] = 8'h00;
        for (int i = 0; i < 9; i++) begin
            wait_hi(rx_ready);
            rx_valid = 1'b1;
            rx_data = b[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
    endtask : send
    // Read 15 reply bytes, stalling the link every other cycle
    task automatic reply(input logic [7:0] sts, input logic [31:0] det, adr);
        logic [7:0] e [15];
        logic [7:0] s;
        e = '{REPLY_HEADER_BYTE, 8'h00, 8'h0a, OPC_TRANSIT, sts,
              det[31:24], det[23:16], det[15:8], det[7:0], adr[31:24],
              adr[23:16], adr[15:8], adr[7:0], 8'h00, END_BYTE};
        if (sts != ST_OK)
            e[3] = OPC_TRANSIT | ERR_BIT;
        s = 8'h00;
        for (int i = 1; i < 13; i++)
            s = s + e[i];
        e[13] = 8'h00 - s;
        for (int i = 0; i < 15; i++) begin
            tx_ready = 1'b0;
            wait_hi(tx_valid);
            tx_ready = 1'b1;
            chk(tx_data, e[i]);
            @(negedge clk);
        end
        tx_ready = 1'b0;
    endtask : reply
    task automatic t_checksum;
        boot(LC_OWNER);
        send(LC_OWNER, LC_LOCKED, 2'h1);
        reply(ST_CHECKSUM, UNUSED_WORD, UNUSED_WORD);
    endtask : t_checksum
    task automatic t_params;
        send(LC_RET_ACK, LC_RET_FIN, 2'h0);
        reply(ST_PARAM, UNUSED_WORD, UNUSED_WORD);
        send(LC_OWNER, LC_RET_FIN, 2'h0);
        reply(ST_PARAM, UNUSED_WORD, UNUSED_WORD);
        lock_en = 1'b0;
        send(LC_OWNER, LC_LOCKED, 2'h0);
        reply(ST_PROTECT, UNUSED_WORD, UNUSED_WORD);
        lock_en = 1'b1;
        send(LC_OWNER, LC_LOCKED, 2'h2);
        reply(ST_PACKET, UNUSED_WORD, UNUSED_WORD);
    endtask : t_params
    task automatic t_flash_then_commit;
        err_mode = 1'b1;
        send(LC_OWNER, LC_LOCKED, 2'h0);
        reply(ST_FLASH, FSTS, FADR);
        chk(lc_state, LC_OWNER);
        err_mode = 1'b0;
        send(LC_OWNER, LC_LOCKED, 2'h0);
        reply(ST_OK, UNUSED_WORD, UNUSED_WORD);
        chk(lc_state, LC_LOCKED);
        chk({halted, rx_ready}, 2'b10);
    endtask : t_flash_then_commit
    task automatic t_return_path;
        boot(LC_RET_ACK);
        send(LC_RET_ACK, LC_RET_FIN, 2'h0);
        reply(ST_OK, UNUSED_WORD, UNUSED_WORD);
        chk({lc_state, halted}, {LC_RET_FIN, 1'b1});
    endtask : t_return_path
    task automatic t_refused_state;
        boot(LC_RET_REQ);
        send(LC_RET_ACK, LC_RET_FIN, 2'h0);
        reply(ST_ACCEPT, UNUSED_WORD, UNUSED_WORD);
        boot(LC_LOCKED);
        repeat (4) @(negedge clk);
        chk({swr, rx_ready}, 2'b10);
    endtask : t_refused_state
    initial begin
        t_checksum();
        t_params();
        t_flash_then_commit();
        t_return_path();
        t_refused_state();
        tally_and_finish();
    end
endmodule : lifecycle_state_transit_cmd_tb
